// ### canfd_chan_regs.vh
`ifndef CANFD_CHAN_REGS_VH
`define CANFD_CHAN_REGS_VH

// register addresses
`define ADDR_NOMINAL_BIT_TIMING    8'h00
`define ADDR_DATA_PHASE_BIT_TIMING 8'h04
`define ADDR_CHANNEL_CONTROL       8'h08
`define ADDR_CHANNEL_STATUS        8'h0C
`define ADDR_IRQ_STATUS            8'h10
`define ADDR_IRQ_ENABLE            8'h14
`define ADDR_IRQ_CLEAR             8'h18
`define ADDR_ERROR_COUNTERS        8'h1C
`define ADDR_QUEUE_HISTORY_CFG     8'h20

// nominal timing fields
`define NBT_PRESCALER_LSB  0
`define NBT_PRESCALER_MSB  9
`define NBT_JUMP_LSB       10
`define NBT_JUMP_MSB       14
`define NBT_SEG1_LSB       16
`define NBT_SEG1_MSB       22
`define NBT_SEG2_LSB       24
`define NBT_SEG2_MSB       28
`define NBT_RESET          32'h0F0F0003

// data phase timing fields
`define DBT_PRESCALER_LSB  0
`define DBT_PRESCALER_MSB  6
`define DBT_SEG1_LSB       8
`define DBT_SEG1_MSB       11
`define DBT_SEG2_LSB       16
`define DBT_SEG2_MSB       18
`define DBT_JUMP_LSB       24
`define DBT_JUMP_MSB       26
`define DBT_RESET          32'h00030303

// channel control fields
`define CTL_MODE_LSB       0
`define CTL_MODE_MSB       1
`define CTL_FORCE_RETURN   3
`define CTL_RECOV_LSB      4
`define CTL_RECOV_MSB      5
`define CTL_ERR_DISPLAY    6
`define CTL_TEST_ENABLE    7
`define CTL_TEST_LSB       8
`define CTL_TEST_MSB       9
`define CTL_CNT_WRITE      10
`define CTL_RESET          32'h00000001
`define CTL_WRITE_MASK     32'h000007F3

// mode codes
`define MODE_OPERATION     2'h0
`define MODE_RESET         2'h1
`define MODE_HALT          2'h2

// recovery codes
`define REC_STANDARD       2'h0
`define REC_HALT_ENTRY     2'h1
`define REC_HALT_AFTER     2'h2
`define REC_SOFTWARE       2'h3

// test codes
`define TEST_LISTEN_ONLY   2'h1
`define TEST_EXT_LOOP      2'h2
`define TEST_INT_LOOP      2'h3

// irq bits
`define IRQ_BUS_ERROR      0
`define IRQ_WARNING        1
`define IRQ_PASSIVE        2
`define IRQ_BUSOFF         3
`define IRQ_RECOVERED      4
`define IRQ_OVERLOAD       5
`define IRQ_BUS_LOCK       6
`define IRQ_ARB_LOST       7
`define IRQ_COUNT          8

// queue and history config bits
`define QH_QUEUE_MODE      0
`define QH_HISTORY_MODE    1
`define QH_HISTORY_ENTRY   2
`define QH_MASK            32'h00000007

// recovery: 11 recessive bits, 128 times
`define RECOVERY_SEQ       8'h80
`define RECOVERY_BITS      4'hB

// sync quantum plus the one added to each segment
`define BIT_EXTRA_QUANTA   2'h3

`define ZERO32             32'h00000000

`endif

// ### bit_quantum_timer.v
`include "canfd_chan_regs.vh"

// quantum and bit tick generator
module bit_quantum_timer #(
    parameter PW = 10,
    parameter S1W = 7,
    parameter S2W = 5
) (
    input  wire           sys_clk,
    input  wire           rstn,
    input  wire           run,
    input  wire [PW-1:0]  prescaler,
    input  wire [S1W-1:0] seg_one,
    input  wire [S2W-1:0] seg_two,
    output reg            quantum_tick,
    output reg            bit_tick
);
    reg [PW-1:0]  pre_cnt_r;
    reg [S1W+1:0] tq_cnt_r;
    wire [S1W+1:0] bit_len;

    // one sync + (seg1+1) + (seg2+1)
    assign bit_len = {2'h0, seg_one} + {{(S1W+2-S2W){1'b0}}, seg_two}
                     + {{S1W{1'b0}}, `BIT_EXTRA_QUANTA};

    always @(posedge sys_clk) begin
        if (!rstn || !run) begin
            pre_cnt_r    <= {PW{1'b0}};
            tq_cnt_r     <= {(S1W+2){1'b0}};
            quantum_tick <= 1'b0;
            bit_tick     <= 1'b0;
        end else begin
            quantum_tick <= 1'b0;
            bit_tick     <= 1'b0;
            if (pre_cnt_r >= prescaler) begin
                pre_cnt_r    <= {PW{1'b0}};
                quantum_tick <= 1'b1;
                if (tq_cnt_r + 1'b1 >= bit_len) begin
                    tq_cnt_r <= {(S1W+2){1'b0}};
                    bit_tick <= 1'b1;
                end else begin
                    tq_cnt_r <= tq_cnt_r + 1'b1;
                end
            end else begin
                pre_cnt_r <= pre_cnt_r + 1'b1;
            end
        end
    end
endmodule

// ### canfd_channel_config_control.v
// The register addresses and the plain strobed port were chosen for this implementation.
`include "canfd_chan_regs.vh"

module canfd_channel_config_control (
    input  wire        sys_clk,
    input  wire        rstn,
    input  wire [7:0]  addr,
    input  wire [31:0] wdata,
    input  wire        wr_en,
    input  wire        rd_en,
    output reg  [31:0] rdata,
    input  wire [7:0]  event_in,
    input  wire        bus_idle_bit,
    input  wire        busoff_entry,
    input  wire        queue_sent,
    input  wire        queue_empty,
    input  wire        history_new_entry,
    input  wire        history_three_quarter,
    input  wire        send_from_queue,
    output reg         irq,
    output reg         queue_irq,
    output reg         history_irq,
    output reg         history_record,
    output reg  [1:0]  channel_mode,
    output reg         busoff,
    output reg         listen_only,
    output reg         external_loop,
    output reg         internal_loop,
    output reg         nominal_bit_tick,
    output reg         fast_bit_tick,
    output reg  [1:0]  test_select
);
    reg  [31:0] nominal_bit_timing_r;
    reg  [31:0] data_phase_bit_timing_r;
    reg  [31:0] channel_control_r;
    reg  [31:0] qh_cfg_r;
    reg  [7:0]  irq_status_r;
    reg  [7:0]  irq_status_nxt;
    reg  [7:0]  irq_enable_r;
    reg  [7:0]  tx_err_cnt_r;
    reg  [7:0]  rx_err_cnt_r;
    reg         err_reported_r;
    reg  [7:0]  seq_cnt_r;
    reg  [3:0]  idle_cnt_r;
    reg         recovering_r;
    wire [7:0]  ev;
    wire        wr_ctl;
    wire [1:0]  mode_w;
    wire [1:0]  recov_w;
    wire        nom_q;
    wire        nom_b;
    wire        fast_q;
    wire        fast_b;
    wire        run;
    wire        test_on;
    wire        recover_done;

    assign wr_ctl = wr_en && (addr == `ADDR_CHANNEL_CONTROL);
    assign mode_w = channel_control_r[`CTL_MODE_MSB:`CTL_MODE_LSB];
    assign recov_w = channel_control_r[`CTL_RECOV_MSB:`CTL_RECOV_LSB];
    assign test_on = channel_control_r[`CTL_TEST_ENABLE];
    assign run = (mode_w != `MODE_RESET);

    assign ev = {event_in[7:1],
                 event_in[`IRQ_BUS_ERROR] &&
                 (channel_control_r[`CTL_ERR_DISPLAY] || !err_reported_r)};

    bit_quantum_timer #(.PW(10), .S1W(7), .S2W(5)) u_nominal (
        .sys_clk      (sys_clk),
        .rstn         (rstn),
        .run          (run),
        .prescaler    (nominal_bit_timing_r[`NBT_PRESCALER_MSB:
                                            `NBT_PRESCALER_LSB]),
        .seg_one      (nominal_bit_timing_r[`NBT_SEG1_MSB:`NBT_SEG1_LSB]),
        .seg_two      (nominal_bit_timing_r[`NBT_SEG2_MSB:`NBT_SEG2_LSB]),
        .quantum_tick (nom_q),
        .bit_tick     (nom_b)
    );

    bit_quantum_timer #(.PW(7), .S1W(4), .S2W(3)) u_fast (
        .sys_clk      (sys_clk),
        .rstn         (rstn),
        .run          (run),
        .prescaler    (data_phase_bit_timing_r[`DBT_PRESCALER_MSB:
                                               `DBT_PRESCALER_LSB]),
        .seg_one      (data_phase_bit_timing_r[`DBT_SEG1_MSB:`DBT_SEG1_LSB]),
        .seg_two      (data_phase_bit_timing_r[`DBT_SEG2_MSB:`DBT_SEG2_LSB]),
        .quantum_tick (fast_q),
        .bit_tick     (fast_b)
    );

    // sticky status, set wins over clear
    always @* begin
        irq_status_nxt = irq_status_r;
        if (wr_en && addr == `ADDR_IRQ_CLEAR) begin
            irq_status_nxt = irq_status_r & ~wdata[7:0];
        end
        irq_status_nxt = irq_status_nxt | ev;
    end

    assign recover_done = recovering_r && bus_idle_bit &&
                          idle_cnt_r == `RECOVERY_BITS - 4'h1 &&
                          seq_cnt_r == `RECOVERY_SEQ - 8'h01;

    always @(posedge sys_clk) begin
        if (!rstn) begin
            nominal_bit_timing_r    <= `NBT_RESET;
            data_phase_bit_timing_r <= `DBT_RESET;
            channel_control_r       <= `CTL_RESET;
            qh_cfg_r                <= `ZERO32;
            irq_status_r            <= 8'h00;
            irq_enable_r            <= 8'h00;
            tx_err_cnt_r            <= 8'h00;
            rx_err_cnt_r            <= 8'h00;
            err_reported_r          <= 1'b0;
            seq_cnt_r               <= 8'h00;
            idle_cnt_r              <= 4'h0;
            recovering_r            <= 1'b0;
            busoff                  <= 1'b0;
            rdata                   <= `ZERO32;
            irq                     <= 1'b0;
            queue_irq               <= 1'b0;
            history_irq             <= 1'b0;
            history_record          <= 1'b0;
            channel_mode            <= `MODE_RESET;
            listen_only             <= 1'b0;
            external_loop           <= 1'b0;
            internal_loop           <= 1'b0;
            nominal_bit_tick        <= 1'b0;
            fast_bit_tick           <= 1'b0;
            test_select             <= 2'h0;
        end else begin
            if (wr_en && addr == `ADDR_NOMINAL_BIT_TIMING) begin
                nominal_bit_timing_r <= {
                    3'h0, wdata[`NBT_SEG2_MSB:`NBT_SEG2_LSB],
                    1'b0, wdata[`NBT_SEG1_MSB:`NBT_SEG1_LSB],
                    1'b0, wdata[`NBT_JUMP_MSB:`NBT_JUMP_LSB],
                    wdata[`NBT_PRESCALER_MSB:`NBT_PRESCALER_LSB]};
            end
            if (wr_en && addr == `ADDR_DATA_PHASE_BIT_TIMING) begin
                data_phase_bit_timing_r <= {
                    5'h00, wdata[`DBT_JUMP_MSB:`DBT_JUMP_LSB],
                    5'h00, wdata[`DBT_SEG2_MSB:`DBT_SEG2_LSB],
                    4'h0, wdata[`DBT_SEG1_MSB:`DBT_SEG1_LSB],
                    1'b0, wdata[`DBT_PRESCALER_MSB:`DBT_PRESCALER_LSB]};
            end
            if (wr_ctl) begin
                channel_control_r <= wdata & `CTL_WRITE_MASK;
                if (wdata[`CTL_MODE_MSB:`CTL_MODE_LSB] == 2'h3) begin
                    channel_control_r[`CTL_MODE_MSB:`CTL_MODE_LSB] <=
                        mode_w;
                end
            end
            if (wr_en && addr == `ADDR_QUEUE_HISTORY_CFG) begin
                qh_cfg_r <= wdata & `QH_MASK;
            end
            if (wr_en && addr == `ADDR_IRQ_ENABLE) begin
                irq_enable_r <= wdata[7:0];
            end
            // counters writable only with enable bit
            if (wr_en && addr == `ADDR_ERROR_COUNTERS &&
                channel_control_r[`CTL_CNT_WRITE]) begin
                tx_err_cnt_r <= wdata[7:0];
                rx_err_cnt_r <= wdata[15:8];
            end
            irq_status_r <= irq_status_nxt;
            // first error latch, set wins; freed on a control write or while in reset mode
            if (ev[`IRQ_BUS_ERROR]) begin
                err_reported_r <= 1'b1;
            end else if (wr_ctl || mode_w == `MODE_RESET) begin
                err_reported_r <= 1'b0;
            end
            // bus-off and recovery
            if (busoff_entry && !busoff) begin
                busoff       <= 1'b1;
                recovering_r <= (recov_w != `REC_SOFTWARE);
                seq_cnt_r    <= 8'h00;
                idle_cnt_r   <= 4'h0;
                if (recov_w == `REC_HALT_ENTRY) begin
                    channel_control_r[`CTL_MODE_MSB:`CTL_MODE_LSB] <=
                        `MODE_HALT;
                end
            end else if (wr_ctl && wdata[`CTL_FORCE_RETURN] && busoff) begin
                busoff       <= 1'b0;
                recovering_r <= 1'b0;
            end else if (recovering_r && nom_b) begin
                if (recover_done) begin
                    busoff       <= 1'b0;
                    recovering_r <= 1'b0;
                    if (recov_w == `REC_HALT_AFTER) begin
                        channel_control_r[`CTL_MODE_MSB:`CTL_MODE_LSB] <=
                            `MODE_HALT;
                    end
                end else if (!bus_idle_bit) begin
                    idle_cnt_r <= 4'h0;
                end else if (idle_cnt_r == `RECOVERY_BITS - 4'h1) begin
                    idle_cnt_r <= 4'h0;
                    seq_cnt_r  <= seq_cnt_r + 8'h01;
                end else begin
                    idle_cnt_r <= idle_cnt_r + 4'h1;
                end
            end
            // register read port
            rdata <= `ZERO32;
            if (rd_en) begin
                case (addr)
                    `ADDR_NOMINAL_BIT_TIMING:
                        rdata <= nominal_bit_timing_r;
                    `ADDR_DATA_PHASE_BIT_TIMING:
                        rdata <= data_phase_bit_timing_r;
                    `ADDR_CHANNEL_CONTROL:
                        rdata <= channel_control_r;
                    `ADDR_CHANNEL_STATUS:
                        rdata <= {28'h0000000, recovering_r, busoff, mode_w};
                    `ADDR_IRQ_STATUS:
                        rdata <= {24'h000000, irq_status_r};
                    `ADDR_IRQ_ENABLE:
                        rdata <= {24'h000000, irq_enable_r};
                    `ADDR_ERROR_COUNTERS:
                        rdata <= {16'h0000, rx_err_cnt_r, tx_err_cnt_r};
                    `ADDR_QUEUE_HISTORY_CFG:
                        rdata <= qh_cfg_r;
                    default:
                        rdata <= `ZERO32;
                endcase
            end
            irq <= |(irq_status_r & irq_enable_r);
            // queue irq on each send, or when empty if the queue mode bit is set
            queue_irq <= qh_cfg_r[`QH_QUEUE_MODE] ?
                         queue_empty : queue_sent;
            history_irq <= qh_cfg_r[`QH_HISTORY_MODE] ?
                           history_three_quarter :
                           history_new_entry;
            history_record <= history_new_entry &&
                              (!qh_cfg_r[`QH_HISTORY_ENTRY] ||
                               send_from_queue);
            channel_mode <= mode_w;
            test_select  <= test_on ?
                channel_control_r[`CTL_TEST_MSB:`CTL_TEST_LSB] : 2'h0;
            // test modes only take effect in halt
            listen_only   <= test_on && mode_w == `MODE_HALT &&
                channel_control_r[`CTL_TEST_MSB:`CTL_TEST_LSB] ==
                `TEST_LISTEN_ONLY;
            external_loop <= test_on && mode_w == `MODE_HALT &&
                channel_control_r[`CTL_TEST_MSB:`CTL_TEST_LSB] ==
                `TEST_EXT_LOOP;
            internal_loop <= test_on && mode_w == `MODE_HALT &&
                channel_control_r[`CTL_TEST_MSB:`CTL_TEST_LSB] ==
                `TEST_INT_LOOP;
            nominal_bit_tick <= nom_b;
            fast_bit_tick    <= fast_b;
        end
    end
endmodule

// ### canfd_cfg_checker.sv
module canfd_cfg_checker (
    input wire logic        sys_clk,
    input wire logic        rstn,
    input wire logic [7:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr_en,
    input wire logic        rd_en,
    input wire logic [31:0] rdata,
    input wire logic        busoff_entry,
    input wire logic [1:0]  channel_mode,
    input wire logic        busoff,
    input wire logic        listen_only,
    input wire logic        external_loop,
    input wire logic        internal_loop,
    input wire logic [1:0]  test_select,
    input wire logic        nominal_bit_tick,
    input wire logic        fast_bit_tick
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    sequence ctl_wr;
        wr_en && addr == 8'h08;
    endsequence
    sequence quiet(logic t);
        (!t) [*4];
    endsequence
    AST_RDATA_IDLE: assert property (!rd_en |=> rdata == 32'h0)
        else $error("read data not zero outside a read");
    AST_MODE_WRITE: assert property (ctl_wr ##0 (wdata[1:0] != 2'h3
        && !busoff && !busoff_entry) |->
        ##2 channel_mode == $past(wdata[1:0], 2))
        else $error("mode field not applied");
    AST_MODE_KEEP: assert property (ctl_wr ##0 (wdata[1:0] == 2'h3
        && !busoff && !busoff_entry) |=> ##1 $stable(channel_mode))
        else $error("invalid mode code changed the mode");
    AST_FORCE_RETURN: assert property (ctl_wr ##0 (wdata[3] && busoff
        && !busoff_entry) |=> !busoff)
        else $error("forced return left bus-off set");
    AST_BUSOFF_ENTRY: assert property (busoff_entry && !wr_en
        && channel_mode == 2'h0 |-> ##[1:2] busoff)
        else $error("bus-off not entered");
    AST_TEST_ONEHOT: assert property (
        $onehot0({listen_only, external_loop, internal_loop}))
        else $error("more than one test mode active");
    AST_TEST_DECODE: assert property (
        listen_only || external_loop || internal_loop |-> test_select ==
        {external_loop || internal_loop, listen_only || internal_loop})
        else $error("test output does not match selection");
    AST_NOMINAL_GAP: assert property (nominal_bit_tick |=>
        quiet(nominal_bit_tick))
        else $error("nominal bit shorter than minimum");
    AST_FAST_GAP: assert property (fast_bit_tick |=>
        quiet(fast_bit_tick))
        else $error("data bit shorter than minimum");
    AST_TIMER_IDLE: assert property ((channel_mode == 2'h1) [*2]
        |-> !nominal_bit_tick && !fast_bit_tick)
        else $error("bit timer runs in reset mode");
endmodule

bind canfd_channel_config_control canfd_cfg_checker chk (
    .sys_clk(sys_clk), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .busoff_entry(busoff_entry), .channel_mode(channel_mode),
    .busoff(busoff), .listen_only(listen_only),
    .external_loop(external_loop), .internal_loop(internal_loop),
    .test_select(test_select), .nominal_bit_tick(nominal_bit_tick),
    .fast_bit_tick(fast_bit_tick));

// ### can_bus_model.sv
module can_bus_model (
    input  wire logic sys_clk,
    output logic [7:0] event_in,
    output logic       bus_idle_bit,
    output logic       busoff_entry,
    output logic [4:0] side
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        event_in = 8'h00;
        bus_idle_bit = 1'b1;  // released bus reads recessive
        busoff_entry = 1'b0;
        side = 5'h00;
    end
    // one-cycle event burst seen from the bus side
    task automatic pulse(input [7:0] e, input b, input [4:0] s);
        @(posedge sys_clk);
        event_in <= e;
        busoff_entry <= b;
        side <= s;
        @(posedge sys_clk);
        event_in <= 8'h00;
        busoff_entry <= 1'b0;
        side <= 5'h00;
    endtask
endmodule

// ### canfd_channel_config_control_bench.sv
module canfd_channel_config_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk;
    logic        rstn;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr_en;
    logic        rd_en;
    logic [31:0] rdata;
    logic [7:0]  event_in;
    logic [4:0]  side;
    logic [1:0]  channel_mode;
    logic [1:0]  test_select;
    logic        bus_idle_bit, busoff_entry, irq, queue_irq, history_irq;
    logic        history_record, busoff, listen_only, external_loop;
    logic        internal_loop, nominal_bit_tick, fast_bit_tick;
    int          mismatches = 0;
    int          samples_checked = 0;
    int          cycles = 0;

    canfd_channel_config_control dut (
        .sys_clk(sys_clk), .rstn(rstn), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .event_in(event_in),
        .bus_idle_bit(bus_idle_bit), .busoff_entry(busoff_entry),
        .queue_sent(side[0]), .queue_empty(side[1]),
        .history_new_entry(side[2]), .history_three_quarter(side[3]),
        .send_from_queue(side[4]), .irq(irq), .queue_irq(queue_irq),
        .history_irq(history_irq), .history_record(history_record),
        .channel_mode(channel_mode), .busoff(busoff),
        .listen_only(listen_only), .external_loop(external_loop),
        .internal_loop(internal_loop), .nominal_bit_tick(nominal_bit_tick),
        .fast_bit_tick(fast_bit_tick), .test_select(test_select));
    can_bus_model bus (
        .sys_clk(sys_clk), .event_in(event_in), .bus_idle_bit(bus_idle_bit),
        .busoff_entry(busoff_entry), .side(side));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic tally_and_finish;
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            tally_and_finish;
        end
    end

    task automatic check(input [31:0] got, input [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input [7:0] a, input [31:0] d);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge sys_clk);
        wr_en <= 1'b0;
        repeat (2) @(posedge sys_clk);
    endtask

    task automatic rd(input [7:0] a, input [31:0] exp);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        #1 check(rdata, exp);
        @(posedge sys_clk);
    endtask

    task automatic ev(input [7:0] e, input b, input [4:0] s);
        bus.pulse(e, b, s);
        repeat (2) @(posedge sys_clk);
    endtask

    // clocks between two bit ticks of the chosen phase
    task automatic period(input logic f, input int exp);
        int n;
        n = 0;
        while ((f ? fast_bit_tick : nominal_bit_tick) !== 1'b1 && n < 3000)
            @(posedge sys_clk) #1 n++;
        n = 0;
        do @(posedge sys_clk) #1 n++;
        while ((f ? fast_bit_tick : nominal_bit_tick) !== 1'b1 && n < 3000);
        check(n, exp);
        @(posedge sys_clk);
    endtask

    // side event, then watch one output for a few cycles
    task automatic qh(input [2:0] c, input [4:0] s, input int o, input exp);
        logic seen;
        seen = 1'b0;
        wr(8'h20, {29'h0, c});
        bus.pulse(8'h00, 1'b0, s);
        repeat (4) begin
            #1;
            seen = seen | (o == 0 ? queue_irq :
                           o == 1 ? history_irq : history_record);
            @(posedge sys_clk);
        end
        check(seen, exp);
        @(posedge sys_clk);
    endtask

    task automatic idle_until_clear(input int lim);
        for (int k = 0; k < lim && busoff === 1'b1; k++)
            @(posedge sys_clk) #1;
        repeat (2) @(posedge sys_clk);
    endtask

    initial begin
        rstn = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        repeat (6) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        rd(8'h00, 32'h0F0F0003);
        rd(8'h04, 32'h00030303);
        rd(8'h08, 32'h00000001);
        wr(8'h3C, 32'hFFFFFFFF);
        rd(8'h3C, 32'h00000000);
        wr(8'h08, 32'h00000002);
        wr(8'h1C, 32'h0000A55A);
        rd(8'h1C, 32'h00000000);
        wr(8'h08, 32'h00000402);
        wr(8'h1C, 32'h0000A55A);
        rd(8'h1C, 32'h0000A55A);
        wr(8'h00, 32'hFFFFFFFF);
        rd(8'h00, 32'h1F7F7FFF);
        wr(8'h04, 32'hFFFFFFFF);
        rd(8'h04, 32'h07070F7F);
        wr(8'h00, 32'h01010001);
        wr(8'h04, 32'h00010200);
        wr(8'h08, 32'h00000000);
        period(1'b0, 10);
        period(1'b1, 6);
        for (int m = 0; m < 4; m++) begin
            wr(8'h08, {30'h0, m[1:0]});
            check(channel_mode, m == 3 ? 2'h2 : m[1:0]);
        end
        for (int s = 1; s < 4; s++) begin
            wr(8'h08, {22'h0, s[1:0], 8'h82});
            check({listen_only,external_loop,internal_loop}, 8 >> s);
            check(test_select, s[1:0]);
        end
        wr(8'h08, 32'h00000302);
        check({listen_only, external_loop, internal_loop}, 3'h0);
        check(test_select, 2'h0);
        wr(8'h08, 32'h00000000);
        wr(8'h14, 32'h000000FF);
        for (int i = 0; i < 8; i++) begin
            ev(8'h01 << i, 1'b0, 5'h00);
            check(irq, 1'b1);
            rd(8'h10, 32'h1 << i);
            wr(8'h18, 32'h1 << i);
            check(irq, 1'b0);
        end
        wr(8'h14, 32'h0000007F);
        ev(8'h80, 1'b0, 5'h00);
        check(irq, 1'b0);
        rd(8'h10, 32'h00000080);
        wr(8'h18, 32'h00000080);
        for (int e = 0; e < 2; e++) begin
            wr(8'h08, {25'h0, e[0], 6'h0});
            ev(8'h01, 1'b0, 5'h00);
            rd(8'h10, 32'h00000001);
            wr(8'h18, 32'h00000001);
            ev(8'h01, 1'b0, 5'h00);
            rd(8'h10, {31'h0, e[0]});
            wr(8'h18, 32'h00000001);
        end
        qh(3'h0, 5'h01, 0, 1'b1);
        qh(3'h0, 5'h02, 0, 1'b0);
        qh(3'h1, 5'h02, 0, 1'b1);
        qh(3'h1, 5'h01, 0, 1'b0);
        qh(3'h0, 5'h04, 1, 1'b1);
        qh(3'h0, 5'h08, 1, 1'b0);
        qh(3'h2, 5'h08, 1, 1'b1);
        qh(3'h2, 5'h04, 1, 1'b0);
        qh(3'h0, 5'h05, 2, 1'b1);
        qh(3'h4, 5'h05, 2, 1'b0);
        qh(3'h4, 5'h15, 2, 1'b1);
        wr(8'h00, 32'h01010000);
        for (int rc = 0; rc < 4; rc++) begin
            wr(8'h08, {26'h0, rc[1:0], 4'h0});
            ev(8'h00, 1'b1, 5'h00);
            check(busoff, 1'b1);
            if (rc == 1)
                check(channel_mode, 2'h2);
            if (rc != 1)
                idle_until_clear(7400);
            check(busoff, rc == 1 || rc == 3);
            if (rc == 2)
                check(channel_mode, 2'h2);
            wr(8'h08, {26'h0, rc[1:0], 4'h8});
            check(busoff, 1'b0);
        end
        tally_and_finish;
    end
endmodule
